//--- design/vadr_map.svh
// Offsets, field positions, reset values and masks of the datapath register group
`ifndef VADR_MAP_SVH
`define VADR_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VADR_OFS_FWD_PATH 8'h28
`define VADR_OFS_DITHER_SYNC 8'h29
`define VADR_OFS_COLOR_TABLE 8'h2a
`define VADR_OFS_AUDIO_CTRL 8'h2b

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VADR_RST_FWD_PATH 8'h20
`define VADR_RST_DITHER_SYNC 8'h00
`define VADR_RST_COLOR_TABLE 8'h00
`define VADR_RST_AUDIO_CTRL 8'h00

// ----------------------------------------
// Writable bit masks, reserved bits excluded
// ----------------------------------------
`define VADR_WMASK_FWD_PATH 8'hbf
`define VADR_WMASK_DITHER_SYNC 8'hff
`define VADR_WMASK_COLOR_TABLE 8'hf0
`define VADR_WMASK_AUDIO_CTRL 8'h03
// Bits the far end may load; the lock bit stays local
`define VADR_FCMASK_FWD_PATH 8'h3f

// ----------------------------------------
// Forward path configuration fields
// ----------------------------------------
`define VADR_FWD_LOCK 7
`define VADR_FWD_VIDEO_OFF 5
`define VADR_FWD_DUAL_LINK 4
`define VADR_FWD_ALT_AUDIO 3
`define VADR_FWD_AUDIO_OFF 2
`define VADR_FWD_WIDE_VIDEO 1
`define VADR_FWD_SURROUND 0

// ----------------------------------------
// Dither and sync configuration fields
// ----------------------------------------
`define VADR_DS_SYNC_MODE 7
`define VADR_DS_HSYNC_POL 6
`define VADR_DS_VSYNC_POL 5
`define VADR_DS_DE_POL 4
`define VADR_DS_DITHER_B_EN 3
`define VADR_DS_DITHER_A_EN 2
`define VADR_DS_DEEP_B_OFF 1
`define VADR_DS_DEEP_A_OFF 0

// ----------------------------------------
// Colour table and audio control fields
// ----------------------------------------
`define VADR_CT_PAGE_HI 7
`define VADR_CT_PAGE_LO 6
`define VADR_CT_WB_EN 5
`define VADR_CT_RELOAD_EN 4
`define VADR_AU_OVERRUN 3
`define VADR_AU_UNDERRUN 2
`define VADR_AU_ERR_RESET 1
`define VADR_AU_RISE_EDGE 0

`endif

//--- design/vadr_pkg.sv
// Types shared by the datapath register group
package vadr_pkg;

   typedef enum logic [1:0] {
      VADR_PAGE_CONFIG = 2'h0,
      VADR_PAGE_RED = 2'h1,
      VADR_PAGE_GREEN = 2'h2,
      VADR_PAGE_BLUE = 2'h3
   } vadr_page_t;

   typedef enum logic [1:0] {
      VADR_IN_AUTO = 2'h0,
      VADR_IN_DUAL = 2'h1,
      VADR_IN_PRIMARY = 2'h2,
      VADR_IN_SECONDARY = 2'h3
   } vadr_in_mode_t;

endpackage : vadr_pkg

//--- design/vadr_audio_err.sv
// Sticky audio FIFO overrun and underrun flags
`timescale 1ns/1ps
module vadr_audio_err (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_overrun,
   input wire logic i_underrun,
   input wire logic i_clear,
   output logic o_overrun_q,
   output logic o_underrun_q
);

   // ----------------------------------------
   // Flags
   // ----------------------------------------
   // [R13] Clear, set wins
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_overrun_q <= 1'b0;
         o_underrun_q <= 1'b0;
      end else begin
         // [R11] Overrun capture
         o_overrun_q <= i_overrun | (o_overrun_q & ~i_clear);
         // [R12] Underrun capture
         o_underrun_q <= i_underrun | (o_underrun_q & ~i_clear);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_err_clear;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_clear && !i_overrun && !i_underrun) |=> (!o_overrun_q && !o_underrun_q);
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("flags not cleared"); // [R13]

   property p_overrun_set;
      @(posedge i_ref_clk) disable iff (i_rst)
      i_overrun |=> o_overrun_q;
   endproperty
   a_overrun_set: assert property (p_overrun_set) else $error("overrun lost"); // [R11]

   property p_underrun_hold;
      @(posedge i_ref_clk) disable iff (i_rst)
      (o_underrun_q && !i_clear) |=> o_underrun_q;
   endproperty
   a_underrun_hold: assert property (p_underrun_hold) else $error("underrun dropped"); // [R12]

endmodule : vadr_audio_err

//--- design/vadr_regs.sv
// Datapath, timing, colour table and audio control register group
// Notes on behaviour
// [R1] Lock bit set: forward-channel loads ignored; clear: far end may load register.
// [R2] Video-disabled resets to one; control channel and pin functions stay on.
// [R3] Dual-link bit tells single or dual link; used in auto-detect input mode.
// [R4] Alternate audio routes word clock to pin 1, data to pin 0; bit 2 mutes audio.
// [R5] Wide-video bit: forward channel carries sync and enable beside pixel data.
// [R6] Surround bit enables multichannel audio output; resets to zero.
// [R7] Timing-mode zero selects enable-only timing; one selects sync timing.
// [R8] Sync and enable polarity bits: zero active high, one active low.
// [R9] Page field: 00 config, 01 red, 10 green, 11 blue table.
// [R10] White-balance bit applies colour table correction, else bypass.
// [R11] Read-only audio FIFO overrun flag at bit 3 of audio register.
// [R12] Read-only audio FIFO underrun flag at bit 2 of audio register.
// [R13] Writing one to error-reset bit clears overrun and underrun flags.
// [R14] Edge bit one strobes audio on rising clock edge, zero falling.
// [R15] Input mode: auto, forced dual, forced primary single, forced secondary single.
// [R16] Dither bits 3,2 enable stages; bits 1,0 disable deep stages.
// [R17] Table reload bit permits colour table reload when set.
// [R18] Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "vadr_map.svh"
module vadr_regs
   import vadr_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   input wire logic i_fc_load,
   input wire logic [7:0] i_fc_data,
   input wire logic [1:0] i_link_input_mode,
   input wire logic i_fifo_overrun,
   input wire logic i_fifo_underrun,
   output logic o_video_active,
   output logic o_ctrl_chan_en,
   output logic o_rx_dual_link,
   output logic o_rx_secondary,
   output logic o_gen_pin_1_wclk_sel,
   output logic o_gen_pin_0_data_sel,
   output logic o_audio_en,
   output logic o_wide_video,
   output logic o_surround_en,
   output logic o_sync_mode,
   output logic o_hsync_pol,
   output logic o_vsync_pol,
   output logic o_data_enable_pol,
   output logic o_dither_stage_b_en,
   output logic o_dither_stage_a_en,
   output logic o_deep_dither_b_en,
   output logic o_deep_dither_a_en,
   output logic [1:0] o_table_page,
   output logic o_wb_en,
   output logic o_table_reload_en,
   output logic o_audio_rise_edge,
   output logic o_fifo_err_clear
);

   // ----------------------------------------
   // Storage and decode
   // ----------------------------------------
   logic [7:0] fwd_q;
   logic [7:0] dsync_q;
   logic [7:0] ctab_q;
   logic [7:0] actl_q;
   logic ovr_q;
   logic und_q;
   logic wr_fwd;
   logic wr_ds;
   logic wr_ct;
   logic wr_au;
   logic fc_take;
   logic err_clr;
   logic [7:0] rd_d;
   vadr_in_mode_t in_mode;

   assign wr_fwd = i_reg_wr && (i_reg_addr == `VADR_OFS_FWD_PATH);
   assign wr_ds = i_reg_wr && (i_reg_addr == `VADR_OFS_DITHER_SYNC);
   assign wr_ct = i_reg_wr && (i_reg_addr == `VADR_OFS_COLOR_TABLE);
   assign wr_au = i_reg_wr && (i_reg_addr == `VADR_OFS_AUDIO_CTRL);
   assign in_mode = vadr_in_mode_t'(i_link_input_mode);

   // [R1] Far-end load gate
   // A local write in the same cycle wins, so software never loses its own value
   assign fc_take = i_fc_load && !fwd_q[`VADR_FWD_LOCK] && !wr_fwd;

   // [R13] Clear on one
   assign err_clr = wr_au && i_reg_wdata[`VADR_AU_ERR_RESET];

   // ----------------------------------------
   // Forward path configuration
   // ----------------------------------------
   // [R2] Video off at reset
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         fwd_q <= `VADR_RST_FWD_PATH;
      end else if (wr_fwd) begin
         // [R18] Reserved masked
         fwd_q <= i_reg_wdata & `VADR_WMASK_FWD_PATH;
      end else if (fc_take) begin
         // [R1] Far-end load
         fwd_q <= (fwd_q & ~`VADR_FCMASK_FWD_PATH) | (i_fc_data & `VADR_FCMASK_FWD_PATH);
      end
   end

   // ----------------------------------------
   // Dither and sync configuration
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         dsync_q <= `VADR_RST_DITHER_SYNC;
      end else if (wr_ds) begin
         dsync_q <= i_reg_wdata & `VADR_WMASK_DITHER_SYNC;
      end
   end

   // ----------------------------------------
   // Colour table configuration
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ctab_q <= `VADR_RST_COLOR_TABLE;
      end else if (wr_ct) begin
         // [R18] Reserved masked
         ctab_q <= i_reg_wdata & `VADR_WMASK_COLOR_TABLE;
      end
   end

   // ----------------------------------------
   // Audio control
   // ----------------------------------------
   // Error-reset bit is kept as written so software can read it back
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         actl_q <= `VADR_RST_AUDIO_CTRL;
      end else if (wr_au) begin
         // [R18] Reserved masked
         actl_q <= i_reg_wdata & `VADR_WMASK_AUDIO_CTRL;
      end
   end

   vadr_audio_err u_audio_err (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_overrun(i_fifo_overrun),
      .i_underrun(i_fifo_underrun),
      .i_clear(err_clr),
      .o_overrun_q(ovr_q),
      .o_underrun_q(und_q)
   );

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      rd_d = 8'h00;
      unique case (i_reg_addr)
         `VADR_OFS_FWD_PATH: rd_d = fwd_q;
         `VADR_OFS_DITHER_SYNC: rd_d = dsync_q;
         `VADR_OFS_COLOR_TABLE: rd_d = ctab_q;
         // [R11] Overrun readback
         // [R12] Underrun readback
         `VADR_OFS_AUDIO_CTRL: rd_d = {4'h0, ovr_q, und_q, actl_q[1:0]};
         default: rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= rd_d;
         end
      end
   end

   // ----------------------------------------
   // Link and video controls
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_video_active <= 1'b0;
         o_ctrl_chan_en <= 1'b0;
         o_rx_dual_link <= 1'b0;
         o_rx_secondary <= 1'b0;
         o_wide_video <= 1'b0;
      end else begin
         // [R2] Control channel kept
         o_video_active <= ~fwd_q[`VADR_FWD_VIDEO_OFF];
         o_ctrl_chan_en <= 1'b1;
         // [R5] Wide video
         o_wide_video <= fwd_q[`VADR_FWD_WIDE_VIDEO];
         // [R15] Input mode select
         unique case (in_mode)
            // [R3] Auto uses dual-link bit
            VADR_IN_AUTO: begin
               o_rx_dual_link <= fwd_q[`VADR_FWD_DUAL_LINK];
               o_rx_secondary <= 1'b0;
            end
            VADR_IN_DUAL: begin
               o_rx_dual_link <= 1'b1;
               o_rx_secondary <= 1'b0;
            end
            VADR_IN_PRIMARY: begin
               o_rx_dual_link <= 1'b0;
               o_rx_secondary <= 1'b0;
            end
            VADR_IN_SECONDARY: begin
               o_rx_dual_link <= 1'b0;
               o_rx_secondary <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Audio controls
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_audio_en <= 1'b0;
         o_gen_pin_1_wclk_sel <= 1'b0;
         o_gen_pin_0_data_sel <= 1'b0;
         o_surround_en <= 1'b0;
         o_audio_rise_edge <= 1'b0;
         o_fifo_err_clear <= 1'b0;
      end else begin
         // [R4] Audio mute and alternate pins
         // Muting audio also frees the general pins for their normal use
         o_audio_en <= ~fwd_q[`VADR_FWD_AUDIO_OFF];
         o_gen_pin_1_wclk_sel <= fwd_q[`VADR_FWD_ALT_AUDIO] & ~fwd_q[`VADR_FWD_AUDIO_OFF];
         o_gen_pin_0_data_sel <= fwd_q[`VADR_FWD_ALT_AUDIO] & ~fwd_q[`VADR_FWD_AUDIO_OFF];
         // [R6] Surround enable
         o_surround_en <= fwd_q[`VADR_FWD_SURROUND] & ~fwd_q[`VADR_FWD_AUDIO_OFF];
         // [R14] Strobe edge
         o_audio_rise_edge <= actl_q[`VADR_AU_RISE_EDGE];
         // [R13] Clear to the FIFO
         o_fifo_err_clear <= err_clr;
      end
   end

   // ----------------------------------------
   // Timing, dither and colour table controls
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sync_mode <= 1'b0;
         o_hsync_pol <= 1'b0;
         o_vsync_pol <= 1'b0;
         o_data_enable_pol <= 1'b0;
         o_dither_stage_b_en <= 1'b0;
         o_dither_stage_a_en <= 1'b0;
         o_deep_dither_b_en <= 1'b0;
         o_deep_dither_a_en <= 1'b0;
         o_table_page <= 2'h0;
         o_wb_en <= 1'b0;
         o_table_reload_en <= 1'b0;
      end else begin
         // [R7] Timing mode
         o_sync_mode <= dsync_q[`VADR_DS_SYNC_MODE];
         // [R8] Polarities, one is active low
         o_hsync_pol <= dsync_q[`VADR_DS_HSYNC_POL];
         o_vsync_pol <= dsync_q[`VADR_DS_VSYNC_POL];
         o_data_enable_pol <= dsync_q[`VADR_DS_DE_POL];
         // [R16] Dither stages
         o_dither_stage_b_en <= dsync_q[`VADR_DS_DITHER_B_EN];
         o_dither_stage_a_en <= dsync_q[`VADR_DS_DITHER_A_EN];
         o_deep_dither_b_en <= ~dsync_q[`VADR_DS_DEEP_B_OFF];
         o_deep_dither_a_en <= ~dsync_q[`VADR_DS_DEEP_A_OFF];
         // [R9] Table page
         o_table_page <= ctab_q[`VADR_CT_PAGE_HI:`VADR_CT_PAGE_LO];
         // [R10] White balance
         o_wb_en <= ctab_q[`VADR_CT_WB_EN];
         // [R17] Reload permit
         o_table_reload_en <= ctab_q[`VADR_CT_RELOAD_EN];
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_lock_ignores;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_fc_load && fwd_q[`VADR_FWD_LOCK] && !i_reg_wr) |=> $stable(fwd_q);
   endproperty
   a_lock_ignores: assert property (p_lock_ignores) else $error("locked load taken"); // [R1]

   property p_fc_loads;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_fc_load && !fwd_q[`VADR_FWD_LOCK] && !i_reg_wr)
         |=> fwd_q[5:0] == $past(i_fc_data[5:0]) ##1 o_wide_video == $past(i_fc_data[1], 2);
   endproperty
   a_fc_loads: assert property (p_fc_loads) else $error("far-end load lost"); // [R1]

   property p_video_flag;
      @(posedge i_ref_clk) disable iff (i_rst)
      (wr_fwd && !i_reg_wdata[5]) |=> ##1 (o_video_active && o_ctrl_chan_en);
   endproperty
   a_video_flag: assert property (p_video_flag) else $error("video flag wrong"); // [R2]

   property p_auto_dual;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_link_input_mode == 2'h0) |=> o_rx_dual_link == $past(fwd_q[4]);
   endproperty
   a_auto_dual: assert property (p_auto_dual) else $error("auto dual wrong"); // [R3]

   property p_alt_pins;
      @(posedge i_ref_clk) disable iff (i_rst)
      (wr_fwd && i_reg_wdata[3] && !i_reg_wdata[2])
         |=> ##1 (o_gen_pin_1_wclk_sel && o_gen_pin_0_data_sel && o_audio_en);
   endproperty
   a_alt_pins: assert property (p_alt_pins) else $error("alternate audio wrong"); // [R4]

   property p_polarity;
      @(posedge i_ref_clk) disable iff (i_rst)
      wr_ds |=> ##1 ({o_sync_mode, o_hsync_pol, o_vsync_pol, o_data_enable_pol}
         == $past(i_reg_wdata[7:4], 2));
   endproperty
   a_polarity: assert property (p_polarity) else $error("timing bits wrong"); // [R8]

   property p_page;
      @(posedge i_ref_clk) disable iff (i_rst)
      wr_ct |=> ##1 (o_table_page == $past(i_reg_wdata[7:6], 2));
   endproperty
   a_page: assert property (p_page) else $error("table page wrong"); // [R9]

   property p_edge;
      @(posedge i_ref_clk) disable iff (i_rst)
      wr_au |=> ##1 (o_audio_rise_edge == $past(i_reg_wdata[0], 2));
   endproperty
   a_edge: assert property (p_edge) else $error("edge select wrong"); // [R14]

   property p_reserved;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_reg_rd && i_reg_addr == `VADR_OFS_COLOR_TABLE) |=> o_reg_rdata[3:0] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved not zero"); // [R18]

   property p_clear_out;
      @(posedge i_ref_clk) disable iff (i_rst)
      (wr_au && i_reg_wdata[1] && !i_fifo_overrun) |=> (o_fifo_err_clear && !ovr_q);
   endproperty
   a_clear_out: assert property (p_clear_out) else $error("clear not applied"); // [R13]

endmodule : vadr_regs

//--- tb/vadr_regs_test.sv
// Self-checking bench for the datapath register group
`timescale 1ns/1ps
`include "vadr_map.svh"
module vadr_regs_test
   import vadr_pkg::*;
;
   // ----------------------------------------
   // Design connections
   // ----------------------------------------
   logic i_ref_clk = 1'b0;
   logic i_rst, i_reg_wr, i_reg_rd, i_fc_load, i_fifo_overrun, i_fifo_underrun;
   logic [7:0] i_reg_addr, i_reg_wdata, i_fc_data, o_reg_rdata;
   logic [1:0] i_link_input_mode, o_table_page;
   logic o_reg_rvalid, o_video_active, o_ctrl_chan_en, o_rx_dual_link, o_rx_secondary;
   logic o_gen_pin_1_wclk_sel, o_gen_pin_0_data_sel, o_audio_en, o_wide_video, o_surround_en;
   logic o_sync_mode, o_hsync_pol, o_vsync_pol, o_data_enable_pol;
   logic o_dither_stage_b_en, o_dither_stage_a_en, o_deep_dither_b_en, o_deep_dither_a_en;
   logic o_wb_en, o_table_reload_en, o_audio_rise_edge, o_fifo_err_clear;
   int err_total = 0;
   int n_checks = 0;

   vadr_regs i_vadr_regs (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .o_reg_rvalid(o_reg_rvalid), .i_fc_load(i_fc_load), .i_fc_data(i_fc_data),
      .i_link_input_mode(i_link_input_mode), .i_fifo_overrun(i_fifo_overrun),
      .i_fifo_underrun(i_fifo_underrun), .o_video_active(o_video_active),
      .o_ctrl_chan_en(o_ctrl_chan_en), .o_rx_dual_link(o_rx_dual_link),
      .o_rx_secondary(o_rx_secondary), .o_gen_pin_1_wclk_sel(o_gen_pin_1_wclk_sel),
      .o_gen_pin_0_data_sel(o_gen_pin_0_data_sel), .o_audio_en(o_audio_en),
      .o_wide_video(o_wide_video), .o_surround_en(o_surround_en), .o_sync_mode(o_sync_mode),
      .o_hsync_pol(o_hsync_pol), .o_vsync_pol(o_vsync_pol),
      .o_data_enable_pol(o_data_enable_pol), .o_dither_stage_b_en(o_dither_stage_b_en),
      .o_dither_stage_a_en(o_dither_stage_a_en), .o_deep_dither_b_en(o_deep_dither_b_en),
      .o_deep_dither_a_en(o_deep_dither_a_en), .o_table_page(o_table_page),
      .o_wb_en(o_wb_en), .o_table_reload_en(o_table_reload_en),
      .o_audio_rise_edge(o_audio_rise_edge), .o_fifo_err_clear(o_fifo_err_clear)
   );

   always #10 i_ref_clk = ~i_ref_clk;

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   // Inputs move 1 ns after the edge so no race with the design's sampling
   task automatic tick();
      @(posedge i_ref_clk);
      #1;
   endtask : tick

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      tick();
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      tick();
      i_reg_wr = 1'b0;
   endtask : reg_write

   // Answer comes on the same edge that takes the strobe, one edge after it is raised
   task automatic read_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
      tick();
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      tick();
      i_reg_rd = 1'b0;
      chk("rvalid", {7'h0, o_reg_rvalid}, 8'h01);
      chk(name, o_reg_rdata, exp);
   endtask : read_chk

   task automatic fc_load(input logic [7:0] d);
      tick();
      i_fc_data = d;
      i_fc_load = 1'b1;
      tick();
      i_fc_load = 1'b0;
   endtask : fc_load

   task automatic fifo_event(input logic ovr, input logic und);
      tick();
      i_fifo_overrun = ovr;
      i_fifo_underrun = und;
      tick();
      i_fifo_overrun = 1'b0;
      i_fifo_underrun = 1'b0;
   endtask : fifo_event

   function automatic logic [7:0] fwd_outs();
      return {o_ctrl_chan_en, o_video_active, o_rx_dual_link, o_gen_pin_1_wclk_sel,
              o_gen_pin_0_data_sel, o_audio_en, o_wide_video, o_surround_en};
   endfunction : fwd_outs

   function automatic logic [7:0] ds_outs();
      return {o_sync_mode, o_hsync_pol, o_vsync_pol, o_data_enable_pol, o_dither_stage_b_en,
              o_dither_stage_a_en, o_deep_dither_b_en, o_deep_dither_a_en};
   endfunction : ds_outs

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      err_total++;
      results();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [1:0] pg;
      logic dual_e;
      int cnt;
      i_rst = 1'b1;
      i_reg_addr = 8'h00;
      i_reg_wdata = 8'h00;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      i_fc_load = 1'b0;
      i_fc_data = 8'h00;
      i_link_input_mode = 2'h0;
      i_fifo_overrun = 1'b0;
      i_fifo_underrun = 1'b0;
      repeat (3) @(posedge i_ref_clk);
      #1;
      i_rst = 1'b0;
      read_chk("fwd_rst", `VADR_OFS_FWD_PATH, 8'h20);
      read_chk("ds_rst", `VADR_OFS_DITHER_SYNC, 8'h00);
      read_chk("ct_rst", `VADR_OFS_COLOR_TABLE, 8'h00);
      read_chk("au_rst", `VADR_OFS_AUDIO_CTRL, 8'h00);
      chk("fwd_outs_rst", fwd_outs(), 8'h84);
      read_chk("unmapped", 8'h2c, 8'h00);
      // Audio disable overrides routing and surround
      reg_write(`VADR_OFS_FWD_PATH, 8'hff);
      tick();
      chk("fwd_outs_ff", fwd_outs(), 8'ha2);
      read_chk("fwd_ff", `VADR_OFS_FWD_PATH, 8'hbf);
      reg_write(`VADR_OFS_FWD_PATH, 8'h0b);
      tick();
      chk("fwd_outs_0b", fwd_outs(), 8'hdf);
      // Far-end loads gated by lock bit
      fc_load(8'hd0);
      read_chk("fc_open", `VADR_OFS_FWD_PATH, 8'h10);
      chk("dual_fc", {7'h0, o_rx_dual_link}, 8'h01);
      reg_write(`VADR_OFS_FWD_PATH, 8'ha0);
      fc_load(8'h1f);
      read_chk("fc_locked", `VADR_OFS_FWD_PATH, 8'ha0);
      for (int m = 0; m < 4; m++) begin
         for (int b = 0; b < 2; b++) begin
            i_link_input_mode = 2'(m);
            reg_write(`VADR_OFS_FWD_PATH, b ? 8'h10 : 8'h00);
            tick();
            dual_e = (m == 0) ? 1'(b) : (m == 1);
            chk("rx_mode", {6'h0, o_rx_dual_link, o_rx_secondary},
                {6'h0, dual_e, m == 3});
         end
      end
      i_link_input_mode = 2'h0;
      // Walking one through timing and dither bits
      for (int i = 0; i < 8; i++) begin
         reg_write(`VADR_OFS_DITHER_SYNC, 8'h01 << i);
         tick();
         chk("ds_outs", ds_outs(), (8'h01 << i) ^ 8'h03);
         read_chk("ds_back", `VADR_OFS_DITHER_SYNC, 8'h01 << i);
      end
      for (int p = 0; p < 4; p++) begin
         pg = 2'(p);
         reg_write(`VADR_OFS_COLOR_TABLE, {pg, ~pg, 4'hf});
         tick();
         chk("ct_outs", {4'h0, o_table_page, o_wb_en, o_table_reload_en},
             {4'h0, pg, ~pg});
         read_chk("ct_back", `VADR_OFS_COLOR_TABLE, {pg, ~pg, 4'h0});
      end
      fifo_event(1'b1, 1'b0);
      read_chk("overrun", `VADR_OFS_AUDIO_CTRL, 8'h08);
      fifo_event(1'b0, 1'b1);
      read_chk("underrun", `VADR_OFS_AUDIO_CTRL, 8'h0c);
      reg_write(`VADR_OFS_AUDIO_CTRL, 8'h01);
      read_chk("flags_kept", `VADR_OFS_AUDIO_CTRL, 8'h0d);
      tick();
      chk("rise_edge", {7'h0, o_audio_rise_edge}, 8'h01);
      tick();
      i_reg_addr = `VADR_OFS_AUDIO_CTRL;
      i_reg_wdata = 8'hf2;
      i_reg_wr = 1'b1;
      tick();
      i_reg_wr = 1'b0;
      // Pulse shows at the first of the next three samples; count over the window to check it lasts one cycle
      cnt = 0;
      for (int k = 0; k < 3; k++) begin
         if (o_fifo_err_clear === 1'b1) cnt++;
         tick();
      end
      chk("clear_pulses", 8'(cnt), 8'h01);
      read_chk("flags_cleared", `VADR_OFS_AUDIO_CTRL, 8'h02);
      chk("fall_edge", {7'h0, o_audio_rise_edge}, 8'h00);
      // Unmapped writes leave no trace
      reg_write(8'h27, 8'hff);
      read_chk("unmapped_wr", 8'h27, 8'h00);
      i_rst = 1'b1;
      tick();
      i_rst = 1'b0;
      read_chk("fwd_rerst", `VADR_OFS_FWD_PATH, 8'h20);
      read_chk("ds_rerst", `VADR_OFS_DITHER_SYNC, 8'h00);
      results();
   end
endmodule : vadr_regs_test
